/* hw/ssc_pkg.sv */
// Shared constants and types for the single-wire switch state controller
package ssc_pkg;

    // Core timebase
    localparam int unsigned CLK_PERIOD_NS     = 100;

    // Pin timeouts in their own unit
    localparam int unsigned LATCH_TIMEOUT_NS  = 2600;
    localparam int unsigned OFF_TIMEOUT_NS    = 2600;

    // Timeouts as whole cycles, least times round up
    localparam int unsigned LATCH_CYCLES =
        (LATCH_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OFF_CYCLES   =
        (OFF_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Timer counter width
    localparam int unsigned TMR_W = 5;

    // Burst counter and switch field widths
    localparam int unsigned CNT_W   = 5;
    localparam int unsigned NUM_SW  = 5;

    // Wrap masks: 32 states for five switches, 8 for three
    localparam logic [CNT_W-1:0] WRAP_MASK_FIVE  = 5'h1f;
    localparam logic [CNT_W-1:0] WRAP_MASK_THREE = 5'h07;

    // Switches that exist in each variant
    localparam logic [NUM_SW-1:0] SW_PRESENT_FIVE  = 5'h1f;
    localparam logic [NUM_SW-1:0] SW_PRESENT_THREE = 5'h07;

    // Reset and step values
    localparam logic [CNT_W-1:0]  CNT_FIRST = 5'h00;
    localparam logic [CNT_W-1:0]  CNT_STEP  = 5'h01;
    localparam logic [NUM_SW-1:0] SW_ALL_OFF = 5'h00;

    // Controller modes, Gray coded along off, count, hold
    typedef enum logic [1:0] {
        SSC_OFF   = 2'b00,
        SSC_COUNT = 2'b01,
        SSC_HOLD  = 2'b11
    } ssc_mode_type;

    // Whole state of the controller
    typedef struct packed {
        ssc_mode_type      mode;
        logic [CNT_W-1:0]  count;
        logic [CNT_W-1:0]  code;
        logic [NUM_SW-1:0] sw_on;
        logic              enabled;
        logic              three_sel;
        logic              uvlo;
        logic              latch_pulse;
    } ssc_ctrl_state_type;

endpackage

/* hw/ssc_pin_if.sv */
// Carrier for the synchronised control pin level and its edges
`timescale 1ns/1ps
interface ssc_pin_if;
    logic level;
    logic rise;
    logic fall;
    logic edge_any;

    modport src
    (
        output level,
        output rise,
        output fall,
        output edge_any
    );

    modport dst
    (
        input level,
        input rise,
        input fall,
        input edge_any
    );
endinterface

/* hw/ssc_pin_sync.sv */
// Two-flop synchroniser and edge detector for the control pin
`timescale 1ns/1ps
module ssc_pin_sync
(
    input  wire logic core_clk_in,
    input  wire logic arst_n_in,
    input  wire logic pin_in,
    ssc_pin_if.src    pin
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } ssc_sync_state_type;

    ssc_sync_state_type q;
    ssc_sync_state_type d;

    // Shift chain; only sync and last feed the edge logic
    always_comb
    begin
        d      = q;
        d.meta = pin_in;
        d.sync = q.meta;
        d.last = q.sync;
    end

    // Pin idles low so reset state is low
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // Edge strobes, one cycle each
    assign pin.level    = q.sync;
    assign pin.rise     = q.sync & ~q.last;
    assign pin.fall     = ~q.sync & q.last;
    assign pin.edge_any = q.sync ^ q.last;

endmodule // ssc_pin_sync

/* hw/ssc_timeout.sv */
// Restartable timeout counter that fires once after a level holds
`timescale 1ns/1ps
module ssc_timeout
#(
    parameter logic [ssc_pkg::TMR_W-1:0] LIMIT = ssc_pkg::TMR_W'(ssc_pkg::LATCH_CYCLES)
)
(
    input  wire logic core_clk_in,
    input  wire logic arst_n_in,
    input  wire logic restart_in,
    input  wire logic run_in,
    output logic      fire_out
);

    typedef struct packed {
        logic [ssc_pkg::TMR_W-1:0] cnt;
        logic                      fire;
    } ssc_tmr_state_type;

    ssc_tmr_state_type q;
    ssc_tmr_state_type d;

    // Count while the level holds, fire once at the limit
    always_comb
    begin
        d      = q;
        d.fire = 1'b0;
        if (restart_in)
        begin
            d.cnt = '0;
        end
        else if (run_in && (q.cnt < LIMIT))
        begin
            d.cnt = q.cnt + ssc_pkg::TMR_W'(1);
            d.fire = (d.cnt == LIMIT);
        end
    end

    // Saturated counter means already fired
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign fire_out = q.fire;

endmodule // ssc_timeout

/* hw/ssc_switch_ctrl.sv */
// Single-wire pulse-count controller driving five or three load switches
`timescale 1ns/1ps

// How it works
// - Each rising edge of the control pin advances the burst counter, decoded to 32 states with five switches.
// - With five switches the counter wraps after 32 edges so edge 33 equals edge 1.
// - The count reaches the switches only after the pin has stayed high for the latch timeout.
// - A disabled controller wakes on the first rising edge and counts it as the first edge.
// - After a latch, further low pulses start a new state that applies after another latch.
// - A low level held for the off timeout disables the controller and turns all switches off.
// - Five-switch decode takes count minus one, a set bit turns that switch off.
// - With three switches the counter decodes eight states and wraps after eight edges.
// - Three-switch decode takes count minus one, a set bit turns that switch off.
// - Every new burst restarts the count from one rather than adding to the old count.
// - An undervoltage indication is registered first and shuts every switch down one edge later.
module ssc_switch_ctrl
(
    input  wire logic core_clk_in,
    input  wire logic arst_n_in,
    input  wire logic ctrl_pin_in,
    input  wire logic uvlo_in,
    input  wire logic variant_three_in,
    output logic      switch_output_1_out,
    output logic      switch_output_2_out,
    output logic      switch_output_3_out,
    output logic      switch_output_4_out,
    output logic      switch_output_5_out,
    output logic      enabled_out,
    output logic      latch_pulse_out,
    output logic [4:0] latched_code_out,
    output logic [4:0] burst_count_out
);

    // Latch and off limits at the timer's width
    // Cut to the timer width on purpose; a longer timeout needs a wider timer
    localparam logic [ssc_pkg::TMR_W-1:0] LATCH_LIMIT =
        ssc_pkg::TMR_W'(ssc_pkg::LATCH_CYCLES);
    localparam logic [ssc_pkg::TMR_W-1:0] OFF_LIMIT =
        ssc_pkg::TMR_W'(ssc_pkg::OFF_CYCLES);

    // State fields, all held in one register:
    // mode, disabled, counting a burst or holding a count;
    // count, edges of the running burst minus one;
    // code, last applied count minus one;
    // sw_on, one bit per switch, high while it conducts;
    // enabled, high from the waking edge to the shutdown;
    // three_sel, registered variant strap;
    // uvlo, registered undervoltage level;
    // latch_pulse, one cycle at each applied count.
    ssc_pkg::ssc_ctrl_state_type q;
    ssc_pkg::ssc_ctrl_state_type d;

    // Timer strobes and variant decode
    logic                          latch_fire;
    logic                          off_fire;
    logic [ssc_pkg::CNT_W-1:0]     wrap_mask;
    logic [ssc_pkg::NUM_SW-1:0]    present;
    logic [ssc_pkg::NUM_SW-1:0]    decoded_on;

    // Pin level and edge strobes
    ssc_pin_if pin ();

    // Limits that the host must keep for a clean count
    // A high or low shorter than one clock period may be lost.
    // Rising edges must lie at least two periods apart.
    // A high gap of the latch timeout inside a burst applies
    // the partial count, so a burst must not pause while high.
    // Bursts are parted by a latch before the next one starts.
    // A low of the off timeout disables the controller,
    // even when it falls in the middle of a burst.
    // Undervoltage is registered once and acts one edge later.

    // pin synchroniser
    // Two flops settle the level, a third one finds its edges
    ssc_pin_sync u_sync
    (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .pin_in      (ctrl_pin_in),
        .pin         (pin.src)
    );

    // latch timer
    // Runs while the pin is high, restarted by any edge.
    // A high gap within a burst never reaches it while the host
    // keeps gaps short, so a partial burst is not applied.
    ssc_timeout
    #(
        .LIMIT (LATCH_LIMIT)
    )
    u_latch_tmr
    (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .restart_in  (pin.edge_any),
        .run_in      (pin.level),
        .fire_out    (latch_fire)
    );

    // off timer
    // Runs while the pin is low, restarted by any edge
    // It also runs while disabled, where its fire is ignored
    // Both timers share the edge strobe as their restart
    ssc_timeout
    #(
        .LIMIT (OFF_LIMIT)
    )
    u_off_tmr
    (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .restart_in  (pin.edge_any),
        .run_in      (~pin.level),
        .fire_out    (off_fire)
    );

    // Variant selection of wrap mask and fitted switches
    // The strap is meant to stay fixed; a change while counting
    // alters the wrap on the next edge and the decode at the
    // next latch, never the switches already applied.
    always_comb
    begin
        if (q.three_sel)
        begin
            wrap_mask = ssc_pkg::WRAP_MASK_THREE;
            present   = ssc_pkg::SW_PRESENT_THREE;
        end
        else
        begin
            wrap_mask = ssc_pkg::WRAP_MASK_FIVE;
            present   = ssc_pkg::SW_PRESENT_FIVE;
        end
    end

    // decode: a set bit of count minus one turns off
    // Count holds n minus one already, so bit i gates switch i+1.
    // Switches that the three-switch variant lacks stay off.
    always_comb
    begin
        for (int i = 0; i < ssc_pkg::NUM_SW; i++)
        begin
            // A set count bit opens the matching switch
            decoded_on[i] = present[i] & ~q.count[i];
        end
    end

    // Latency of the pin path in core clock edges, counted from
    // the edge after which the host changes the pin:
    // edge 1, first synchroniser stage takes the new level;
    // edge 2, second stage holds it and the edge strobe is valid;
    // edge 3, the controller counts and both timers restart;
    // edge 4, the timer of the held level takes its first step;
    // edge 29, that timer reaches the default limit and fires;
    // edge 30, switches, latched code and latch pulse update;
    // edge 31, the latch pulse drops again.
    // A held low follows the same path, ending in a shutdown.
    // A limit of another size moves the last three edges.

    // Next-state logic of the controller
    always_comb
    begin
        d             = q;
        d.latch_pulse = 1'b0;
        // Variant strap sampled by a clock, never by the reset
        d.three_sel   = variant_three_in;
        // Registered undervoltage level
        d.uvlo        = uvlo_in;

        if (q.uvlo)
        begin
            // undervoltage forces shutdown
            // The count is dropped too, so the first edge after
            // recovery wakes the controller as from reset
            d.mode    = ssc_pkg::SSC_OFF;
            d.count   = ssc_pkg::CNT_FIRST;
            d.sw_on   = ssc_pkg::SW_ALL_OFF;
            d.enabled = 1'b0;
        end
        else
        begin
            case (q.mode)
                // Disabled: switches off, waiting for a waking edge
                ssc_pkg::SSC_OFF:
                begin
                    if (pin.rise)
                    begin
                        // first edge enables and counts as one
                        // Count zero stands for one edge
                        d.mode    = ssc_pkg::SSC_COUNT;
                        d.count   = ssc_pkg::CNT_FIRST;
                        d.enabled = 1'b1;
                    end
                end

                // Counting a burst: rise before latch before off
                // A rise can meet an off fire in the same cycle; the rise wins and the fire is lost
                ssc_pkg::SSC_COUNT:
                begin
                    if (pin.rise)
                    begin
                        // advance with wrap on every edge
                        // The mask folds the count to zero after the last state
                        d.count = (q.count + ssc_pkg::CNT_STEP) & wrap_mask;
                    end
                    else if (latch_fire)
                    begin
                        // apply count after the latch timeout
                        // The code keeps the applied count for status
                        d.mode        = ssc_pkg::SSC_HOLD;
                        d.code        = q.count;
                        d.sw_on       = decoded_on;
                        d.latch_pulse = 1'b1;
                    end
                    else if (off_fire)
                    begin
                        d.mode    = ssc_pkg::SSC_OFF;
                        d.count   = ssc_pkg::CNT_FIRST;
                        d.sw_on   = ssc_pkg::SW_ALL_OFF;
                        d.enabled = 1'b0;
                    end
                end

                // Holding a count: a rise opens a new burst
                // The latch timer is saturated while the pin stays high, at zero once it falls, and fires no more
                ssc_pkg::SSC_HOLD:
                begin
                    if (pin.rise)
                    begin
                        // new burst restarts the count at one
                        d.mode  = ssc_pkg::SSC_COUNT;
                        d.count = ssc_pkg::CNT_FIRST;
                    end
                    else if (off_fire)
                    begin
                        d.mode    = ssc_pkg::SSC_OFF;
                        d.count   = ssc_pkg::CNT_FIRST;
                        d.sw_on   = ssc_pkg::SW_ALL_OFF;
                        d.enabled = 1'b0;
                    end
                end

                default:
                begin
                    // Unused code recovers to disabled
                    d.mode    = ssc_pkg::SSC_OFF;
                    d.count   = ssc_pkg::CNT_FIRST;
                    d.sw_on   = ssc_pkg::SW_ALL_OFF;
                    d.enabled = 1'b0;
                end
            endcase
        end
    end

    // state register, reset leaves all off and disabled
    // Only constants in the reset branch; the strap and the
    // undervoltage level are picked up at the first edge
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            q.mode        <= ssc_pkg::SSC_OFF;
            q.count       <= ssc_pkg::CNT_FIRST;
            q.code        <= ssc_pkg::CNT_FIRST;
            q.sw_on       <= ssc_pkg::SW_ALL_OFF;
            q.enabled     <= 1'b0;
            q.three_sel   <= 1'b0;
            q.uvlo        <= 1'b0;
            q.latch_pulse <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    // Switch outputs, high means the switch conducts
    // Every output is a register bit, so no decode glitch
    // reaches the load switches
    assign switch_output_1_out = q.sw_on[0];
    assign switch_output_2_out = q.sw_on[1];
    assign switch_output_3_out = q.sw_on[2];
    assign switch_output_4_out = q.sw_on[3];
    assign switch_output_5_out = q.sw_on[4];

    // Status outputs
    // Latch pulse and latched code change at the same edge as the switches
    assign enabled_out      = q.enabled;
    assign latch_pulse_out  = q.latch_pulse;
    assign latched_code_out = q.code;       // Last applied count minus one
    assign burst_count_out  = q.count;      // Running count minus one

endmodule // ssc_switch_ctrl

/* bench/ssc_switch_ctrl_properties.sv */
// Concurrent checks on the switch controller ports
`timescale 1ns/1ps
module ssc_switch_ctrl_properties
(
    input wire logic       core_clk_in,
    input wire logic       arst_n_in,
    input wire logic       ctrl_pin_in,
    input wire logic       uvlo_in,
    input wire logic       variant_three_in,
    input wire logic       switch_output_1_out,
    input wire logic       switch_output_2_out,
    input wire logic       switch_output_3_out,
    input wire logic       switch_output_4_out,
    input wire logic       switch_output_5_out,
    input wire logic       enabled_out,
    input wire logic       latch_pulse_out,
    input wire logic [4:0] latched_code_out,
    input wire logic [4:0] burst_count_out
);
    logic [5:0] high_cnt;
    logic [5:0] low_cnt;
    logic [4:0] sw;

    // Switch levels as one vector, bit 0 is switch 1
    assign sw = {switch_output_5_out, switch_output_4_out, switch_output_3_out,
                 switch_output_2_out, switch_output_1_out};

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    // Saturating run lengths of the raw pin level
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            high_cnt <= 6'h00;
            low_cnt  <= 6'h00;
        end
        else
        begin
            high_cnt <= !ctrl_pin_in ? 6'h00 : high_cnt + 6'(high_cnt != 6'h3f);
            low_cnt  <= ctrl_pin_in ? 6'h00 : low_cnt + 6'(low_cnt != 6'h3f);
        end
    end

    chk_pulse_single:
    assert property (latch_pulse_out |=> !latch_pulse_out)
        else $error("latch pulse longer than one cycle");
    chk_latch_wait:
    assert property (latch_pulse_out |-> high_cnt >= 6'h1a)
        else $error("latch before pin held high long enough");
    chk_first_edge:
    assert property ($rose(enabled_out) |-> burst_count_out == 5'h00)
        else $error("waking edge not counted as first");
    chk_count_step:
    assert property ($changed(burst_count_out) && burst_count_out != 5'h00
                     |-> burst_count_out == 5'($past(burst_count_out) + 5'h01))
        else $error("burst count skipped a value");
    chk_decode_five:
    assert property (latch_pulse_out && !uvlo_in && !variant_three_in
                     |=> sw == ~latched_code_out)
        else $error("five switch decode wrong");
    chk_decode_three:
    assert property (latch_pulse_out && !uvlo_in && variant_three_in
                     |=> sw == {2'b00, ~latched_code_out[2:0]} && latched_code_out[4:3] == 2'b00)
        else $error("three switch decode wrong");
    chk_uvlo_off:
    assert property (uvlo_in |-> ##2 sw == 5'h00)
        else $error("switches on under undervoltage");
    chk_off_timeout:
    assert property (low_cnt >= 6'h28 |-> !enabled_out && sw == 5'h00)
        else $error("still enabled after long low");
    chk_fall_off:
    assert property ($fell(enabled_out) |-> sw == 5'h00)
        else $error("switches left on when disabled");
endmodule // ssc_switch_ctrl_properties

bind ssc_switch_ctrl ssc_switch_ctrl_properties ssc_switch_ctrl_properties_inst
(
    .core_clk_in, .arst_n_in, .ctrl_pin_in, .uvlo_in, .variant_three_in,
    .switch_output_1_out, .switch_output_2_out, .switch_output_3_out,
    .switch_output_4_out, .switch_output_5_out, .enabled_out, .latch_pulse_out,
    .latched_code_out, .burst_count_out
);

/* bench/ssc_host_model.sv */
// Host pin driver that sends pulse bursts at 1 MHz
`timescale 1ns/1ps
module ssc_host_model
(
    input  wire logic       core_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       go_in,
    input  wire logic [5:0] len_in,
    input  wire logic       low_in,
    output logic            pin_out,
    output logic            busy_out
);
    logic [5:0] rem_q;
    logic [3:0] ph_q;
    logic       pin_q;

    // ten cycle pulses, five high, pin left high to latch
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rem_q <= 6'h00;
            ph_q  <= 4'h0;
            pin_q <= 1'b0;
        end
        else if (go_in)
        begin
            rem_q <= len_in;
            ph_q  <= 4'h0;
            pin_q <= 1'b0;
        end
        else if (rem_q != 6'h00)
        begin
            pin_q <= ph_q >= 4'h5;
            ph_q  <= (ph_q == 4'h9) ? 4'h0 : ph_q + 4'h1;
            if (ph_q == 4'h9)
            begin
                rem_q <= rem_q - 6'h01;
            end
        end
    end

    // Pin forced low to disable the device
    assign pin_out  = low_in ? 1'b0 : pin_q;
    assign busy_out = rem_q != 6'h00;
endmodule // ssc_host_model

/* bench/ssc_switch_ctrl_tb_top.sv */
// Self-checking bench for the switch controller
`timescale 1ns/1ps
module ssc_switch_ctrl_tb_top;
    logic       core_clk = 1'b0;
    logic       arst_n   = 1'b0;
    logic       uvlo     = 1'b0;
    logic       three    = 1'b0;
    logic       go       = 1'b0;
    logic       low      = 1'b0;
    logic [5:0] len      = 6'h00;
    logic       pin;
    logic       busy;
    logic       en;
    logic [4:0] sw;
    logic [4:0] code;
    logic [4:0] cnt;
    int         errors      = 0;
    int         check_count = 0;
    int         cycles      = 0;

    ssc_host_model ssc_host_model_inst (.core_clk_in(core_clk), .arst_n_in(arst_n),
        .go_in(go), .len_in(len), .low_in(low), .pin_out(pin), .busy_out(busy));
    ssc_switch_ctrl ssc_switch_ctrl_inst (.core_clk_in(core_clk), .arst_n_in(arst_n),
        .ctrl_pin_in(pin), .uvlo_in(uvlo), .variant_three_in(three),
        .switch_output_1_out(sw[0]), .switch_output_2_out(sw[1]),
        .switch_output_3_out(sw[2]), .switch_output_4_out(sw[3]),
        .switch_output_5_out(sw[4]), .enabled_out(en), .latch_pulse_out(),
        .latched_code_out(code), .burst_count_out(cnt));

    // 10 MHz clock
    initial forever #50 core_clk = ~core_clk;

    // Hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [4:0] exp, input logic [4:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Switch pattern for a burst of n pulses
    function automatic logic [4:0] exp_sw(input int n);
        logic [4:0] c;
        c = 5'(n - 1);
        if (three)
            return ~(c & ssc_pkg::WRAP_MASK_THREE) & ssc_pkg::SW_PRESENT_THREE;
        return ~c;
    endfunction

    task automatic reset_dut(input logic v);
        @(posedge core_clk);
        arst_n <= 1'b0;
        three  <= v;
        low    <= 1'b0;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
    endtask

    task automatic burst(input int n);
        int k;
        @(posedge core_clk);
        go  <= 1'b1;
        len <= 6'(n);
        @(posedge core_clk);
        go <= 1'b0;
        k = 0;
        @(negedge core_clk);
        while (busy === 1'b1 && k < 800)
        begin
            @(negedge core_clk);
            k++;
        end
        repeat (45) @(negedge core_clk);
    endtask

    task automatic t_reset;
        check("switches", 5'h00, sw);
        check("enabled", 5'h00, {4'h0, en});
        $display("test reset done");
    endtask

    task automatic t_first;
        burst(1);
        check("enabled", 5'h01, {4'h0, en});
        check("switches", 5'h1f, sw);
        $display("test first edge done");
    endtask

    task automatic t_decode;
        for (int n = 2; n <= 33; n++)
        begin
            burst(n);
            check("switches", exp_sw(n), sw);
            check("code", 5'(n - 1), code);
            check("count", 5'(n - 1), cnt);
        end
        $display("test five decode done");
    endtask

    task automatic t_seq;
        logic [4:0] want [5] = '{5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f};
        int         steps [5] = '{16, 8, 4, 2, 1};
        for (int i = 0; i < 5; i++)
        begin
            burst(steps[i]);
            check("switches", want[i], sw);
        end
        $display("test sequencing done");
    endtask

    task automatic t_uvlo;
        @(posedge core_clk);
        uvlo <= 1'b1;
        repeat (3) @(negedge core_clk);
        check("switches", 5'h00, sw);
        burst(3);
        check("switches", 5'h00, sw);
        @(posedge core_clk);
        uvlo <= 1'b0;
        burst(2);
        check("switches", exp_sw(2), sw);
        $display("test undervoltage done");
    endtask

    task automatic t_off;
        @(posedge core_clk);
        low <= 1'b1;
        repeat (10) @(negedge core_clk);
        check("enabled", 5'h01, {4'h0, en});
        repeat (30) @(negedge core_clk);
        check("enabled", 5'h00, {4'h0, en});
        check("switches", 5'h00, sw);
        $display("test off timeout done");
    endtask

    task automatic t_three;
        reset_dut(1'b1);
        for (int n = 1; n <= 9; n++)
        begin
            burst(n);
            check("switches", exp_sw(n), sw);
            check("code", 5'(n - 1) & ssc_pkg::WRAP_MASK_THREE, code);
        end
        $display("test three decode done");
    endtask

    // Main sequence
    initial
    begin
        reset_dut(1'b0);
        t_reset();
        t_first();
        t_decode();
        t_seq();
        t_uvlo();
        t_off();
        t_three();
        wrap_up();
    end
endmodule // ssc_switch_ctrl_tb_top
